/* rtl/can_mb_pkg.sv */
// Shared constants and types for the CAN message buffer block
// Contract
// (R1) Remote request hitting a remote-answer transmit slot turns its code to 1110.
// (R2) Extended slot keeps identifier bits 28..15 in the upper identifier word.
// (R3) SRR is written one by software; receive slots store it as received.
// (R4) IDE one selects extended format, zero selects standard format.
// (R5) Extended slot keeps identifier bits 14..0 in the lower identifier word.
// (R6) Extended slot takes RTR from bit 0 of the lower word.
// (R7) Standard slot lower word receives the 16-bit timer captured at identifier start.
// (R8) Software writes standard identifier high bits and zeros in the low four.
// (R9) Standard slot takes RTR from the upper identifier word.
// (R10) Sent one seen zero is arbitration loss; zero seen one is bit error.
// (R11) Two hidden shadow buffers, one active at a time, never software visible.
// (R12) Activating code joins a slot to processing; deactivating code removes it.
// (R13) Software deactivates a slot before changing direction, identifier or payload.
// (R14) Reading a receive slot control word locks it against shadow transfers.
// (R15) Reading during a transfer into the slot shows busy and sets no lock.
// (R16) Reading another slot control word moves the single lock there.
// (R17) Reading the free-running timer releases any lock.
// (R18) After release, a held-back shadow transfer proceeds.
// (R19) Slots 0 to 13 share one mask; slots 14 and 15 have own masks.
// (R20) A frame matched to a locked slot is delivered later despite mask changes.
// (R21) Mask bit zero ignores an identifier bit; one requires equality.
// (R22) Receive codes 0000/0100/0010/0110; busy clears within 20 cycles.
// (R23) Transmit codes 1000, 1100, 1010, 1110 with their after-send codes.
// (R24) Control word time stamp gets timer high byte from identifier start.
// (R25) Acceptance also requires the frame format to equal the slot IDE bit.
package can_buf_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_WORDS = 8;
  localparam int ID_BITS = 29;
  localparam logic [3:0] SLOT_MASK_A = 4'hE;
  localparam logic [3:0] SLOT_MASK_B = 4'hF;

  // Word index inside a slot (two bytes per word)
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_UPPER = 3'h1;
  localparam logic [2:0] W_LOWER = 3'h2;
  localparam logic [2:0] W_DATA0 = 3'h3;
  localparam logic [2:0] W_RSV = 3'h7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TS_LSB = 8;
  localparam int CODE_LSB = 4;
  localparam int LEN_LSB = 0;
  localparam int UP_SRR_BIT = 4;
  localparam int UP_RTR_STD_BIT = 4;
  localparam int UP_IDE_BIT = 3;
  localparam int LO_RTR_BIT = 0;
  localparam logic [15:0] CODE_BUSY_MASK = 16'h0010;

  // ------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------
  localparam logic [3:0] RX_INACTIVE = 4'h0;
  localparam logic [3:0] RX_EMPTY = 4'h4;
  localparam logic [3:0] RX_FULL = 4'h2;
  localparam logic [3:0] RX_OVERRUN = 4'h6;
  localparam logic [3:0] TX_NOT_READY = 4'h8;
  localparam logic [3:0] TX_ONCE = 4'hC;
  localparam logic [3:0] TX_REMOTE = 4'hA;
  localparam logic [3:0] TX_ONCE_REMOTE = 4'hE;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam int BUSY_MAX_CYCLES = 20;
  localparam logic [4:0] XFER_CYCLES = 5'h04;

  typedef logic [3:0] slot_idx_t;

endpackage

/* rtl/can_id_filter.sv */
// Acceptance filter: one hit bit per slot
`timescale 1ns/10ps
module can_id_filter
  import can_buf_pkg::*;
(
  // Clock and reset, used only by checks
  input wire logic clk,
  input wire logic rst_n,
  // Incoming frame
  input wire logic [28:0] frame_id,
  input wire logic frame_ide,
  // Masks
  input wire logic [28:0] global_mask,
  input wire logic [28:0] mask14,
  input wire logic [28:0] mask15,
  // Slot identifier words
  input wire logic [15:0] slot_upper [can_buf_pkg::NUM_SLOTS],
  input wire logic [15:0] slot_lower [can_buf_pkg::NUM_SLOTS],
  // Result
  output logic [15:0] hit
);
  import can_buf_pkg::*;

  for (genvar s = 0; s < NUM_SLOTS; s++)
  begin : g_slot
    wire slot_ide = slot_upper[s][UP_IDE_BIT]; // R4
    wire [28:0] slot_id = slot_ide ?
      {slot_upper[s][15:5], slot_upper[s][2:0], slot_lower[s][15:1]} :
      {slot_upper[s][15:5], 18'h00000}; // R2 R5
    wire [28:0] raw_mask = (s == SLOT_MASK_A) ? mask14 :
      (s == SLOT_MASK_B) ? mask15 : global_mask; // R19
    // Standard frames carry no low identifier bits to compare
    wire [28:0] eff_mask = slot_ide ? raw_mask :
      {raw_mask[28:18], 18'h00000};
    wire id_ok = ((frame_id ^ slot_id) & eff_mask) == 29'h00000000; // R21
    assign hit[s] = id_ok && (frame_ide == slot_ide); // R25

    property p_hit_format;
      @(posedge clk) disable iff (!rst_n)
      hit[s] |-> (frame_ide == slot_upper[s][UP_IDE_BIT]) &&
        (((frame_id ^ slot_id) & eff_mask) == 29'h00000000);
    endproperty
    a_hit_format: assert property (p_hit_format) // R21
      else $error("filter hit with mismatched format or identifier");
  end

endmodule // can_id_filter

/* rtl/can_bit_check.sv */
// Transmitted versus sampled bit comparison
`timescale 1ns/10ps
module can_bit_check (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bit sample
  input wire logic bit_strobe,
  input wire logic bit_sent,
  input wire logic bit_seen,
  // Verdicts, one-cycle pulses
  output logic arb_lost,
  output logic bit_error,
  output logic bit_ok
);

  wire lost_now = bit_strobe && bit_sent && !bit_seen;
  wire err_now = bit_strobe && !bit_sent && bit_seen;
  wire ok_now = bit_strobe && (bit_sent == bit_seen);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arb_lost <= 1'b0;
      bit_error <= 1'b0;
      bit_ok <= 1'b0;
    end
    else
    begin
      arb_lost <= lost_now; // R10
      bit_error <= err_now; // R10
      bit_ok <= ok_now; // R10
    end
  end

  property p_arb_lost;
    @(posedge clk) disable iff (!rst_n)
    bit_strobe && bit_sent && !bit_seen |=> arb_lost && !bit_error && !bit_ok;
  endproperty
  a_arb_lost: assert property (p_arb_lost) // R10
    else $error("recessive sent, dominant seen, no arbitration loss");

  property p_bit_error;
    @(posedge clk) disable iff (!rst_n)
    bit_strobe && !bit_sent && bit_seen |=> bit_error && !arb_lost && !bit_ok;
  endproperty
  a_bit_error: assert property (p_bit_error) // R10
    else $error("dominant sent, recessive seen, no bit error");

endmodule // can_bit_check

/* rtl/can_message_buffer_filter.sv */
// Message slots, shadow buffers, lock logic and acceptance
`timescale 1ns/10ps
module can_message_buffer_filter
  import can_buf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host access to slot words
  input wire can_buf_pkg::slot_idx_t host_sel,
  input wire logic [2:0] host_word,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // Free-running timer read
  input wire logic timer_rd,
  output logic [15:0] timer_rdata,
  // Acceptance masks
  input wire logic [28:0] global_mask,
  input wire logic [28:0] mask14,
  input wire logic [28:0] mask15,
  // Received frames from the protocol engine
  input wire logic rx_id_start,
  input wire logic rx_frame_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic rx_srr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic rx_dropped,
  // Transmit side
  input wire logic tx_done,
  input wire can_buf_pkg::slot_idx_t tx_slot,
  output logic [15:0] tx_pending,
  input wire logic bit_strobe,
  input wire logic bit_sent,
  input wire logic bit_seen,
  output logic arb_lost,
  output logic bit_error,
  output logic bit_ok,
  // Lock status
  output logic lock_valid,
  output can_buf_pkg::slot_idx_t lock_slot
);
  import can_buf_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  typedef enum logic {X_IDLE, X_BUSY} xfer_state_t;

  logic [15:0] mem [NUM_SLOTS][SLOT_WORDS];
  logic [15:0] timer;
  logic [15:0] ts_cap;
  // Shadow buffers: internal only, no host path reads them
  logic [15:0] sh_upper [2];
  logic [15:0] sh_lower [2];
  logic [15:0] sh_ts [2];
  logic [3:0] sh_dlc [2];
  logic [63:0] sh_data [2];
  slot_idx_t sh_target [2];
  logic [1:0] sh_full;
  xfer_state_t xfer_state;
  logic xfer_sh;
  slot_idx_t xfer_slot;
  logic [4:0] xfer_cnt;

  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
      if (v[i])
        r = {1'b1, 4'(i)};
    return r;
  endfunction

  // ------------------------------------------------------------
  // Per-slot decode
  // ------------------------------------------------------------
  logic [15:0] slot_upper [NUM_SLOTS];
  logic [15:0] slot_lower [NUM_SLOTS];
  logic [3:0] slot_code [NUM_SLOTS];
  logic [15:0] slot_rtr;
  logic [15:0] rx_ready;
  logic [15:0] remote_ready;
  logic [15:0] tx_ready;
  logic [15:0] hit;

  for (genvar s = 0; s < NUM_SLOTS; s++)
  begin : g_slot
    assign slot_upper[s] = mem[s][W_UPPER];
    assign slot_lower[s] = mem[s][W_LOWER];
    assign slot_code[s] = mem[s][W_CTRL][CODE_LSB+:4];
    assign slot_rtr[s] = mem[s][W_UPPER][UP_IDE_BIT] ?
      mem[s][W_LOWER][LO_RTR_BIT] : mem[s][W_UPPER][UP_RTR_STD_BIT]; // R6 R9
    // Inactive and not-ready slots take no part
    assign rx_ready[s] = (slot_code[s] == RX_EMPTY) ||
      (slot_code[s] == RX_FULL) || (slot_code[s] == RX_OVERRUN); // R12
    assign remote_ready[s] = slot_code[s] == TX_REMOTE;
    assign tx_ready[s] = (slot_code[s] == TX_ONCE) ||
      (slot_code[s] == TX_ONCE_REMOTE); // R12
  end

  can_id_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .frame_id(rx_id),
    .frame_ide(rx_ide),
    .global_mask(global_mask),
    .mask14(mask14),
    .mask15(mask15),
    .slot_upper(slot_upper),
    .slot_lower(slot_lower),
    .hit(hit)
  );

  can_bit_check u_bit (
    .clk(clk),
    .rst_n(rst_n),
    .bit_strobe(bit_strobe),
    .bit_sent(bit_sent),
    .bit_seen(bit_seen),
    .arb_lost(arb_lost),
    .bit_error(bit_error),
    .bit_ok(bit_ok)
  );

  // ------------------------------------------------------------
  // Incoming frame handling
  // ------------------------------------------------------------
  wire [15:0] frm_upper = rx_ide ?
    {rx_id[28:18], rx_srr, 1'b1, rx_id[17:15]} :
    {rx_id[28:18], rx_rtr, 4'h0}; // R2 R3 R4
  wire [15:0] frm_lower = rx_ide ? {rx_id[14:0], rx_rtr} : ts_cap; // R5 R7
  wire [4:0] rx_pick = first_set(hit & rx_ready);
  wire rx_match = rx_frame_valid && !rx_rtr && rx_pick[4];
  wire [15:0] remote_hit = (rx_frame_valid && rx_rtr) ?
    (hit & remote_ready) : 16'h0000;
  wire [4:0] remote_pick = first_set(remote_hit);
  // Only one shadow is filled at a time: the first free one
  wire sh_free_idx = sh_full[0];
  wire sh_free_ok = !(&sh_full);
  wire sh_store = rx_match && sh_free_ok; // R11

  // ------------------------------------------------------------
  // Transfer engine, shadow to slot
  // ------------------------------------------------------------
  logic [1:0] sh_elig;
  for (genvar i = 0; i < 2; i++)
  begin : g_elig
    assign sh_elig[i] = sh_full[i] &&
      !(lock_valid && lock_slot == sh_target[i]); // R14 R18
  end
  wire xfer_pick = !sh_elig[0];
  wire ctrl_rd = host_rd && (host_word == W_CTRL);
  wire xfer_start = (xfer_state == X_IDLE) && (|sh_elig) && !ctrl_rd;
  wire xfer_busy = xfer_state == X_BUSY;
  wire xfer_done = xfer_busy && (xfer_cnt == 5'h00);
  wire [3:0] dest_code = slot_code[xfer_slot];
  wire dest_live = rx_ready[xfer_slot];
  wire [3:0] next_rx_code = (dest_code == RX_EMPTY) ?
    RX_FULL : RX_OVERRUN; // R22
  wire [1:0] sh_clear = xfer_done ? (2'b01 << xfer_sh) : 2'b00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_state <= X_IDLE;
      xfer_sh <= 1'b0;
      xfer_slot <= 4'h0;
      xfer_cnt <= 5'h00;
    end
    else
    begin
      unique case (xfer_state)
        X_IDLE:
          if (xfer_start)
          begin
            xfer_state <= X_BUSY;
            xfer_sh <= xfer_pick;
            xfer_slot <= sh_target[xfer_pick];
            xfer_cnt <= XFER_CYCLES - 5'h01;
          end
        X_BUSY:
          if (xfer_done)
            xfer_state <= X_IDLE; // R22
          else
            xfer_cnt <= xfer_cnt - 5'h01;
      endcase
    end
  end

  // Target is fixed at match time, so later mask edits do not matter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_full <= 2'b00;
      for (int i = 0; i < 2; i++)
      begin
        sh_upper[i] <= WORD_RESET;
        sh_lower[i] <= WORD_RESET;
        sh_ts[i] <= WORD_RESET;
        sh_dlc[i] <= 4'h0;
        sh_data[i] <= 64'h0000000000000000;
        sh_target[i] <= 4'h0;
      end
    end
    else
    begin
      sh_full <= sh_full & ~sh_clear;
      if (sh_store)
      begin
        sh_full[sh_free_idx] <= 1'b1;
        sh_upper[sh_free_idx] <= frm_upper;
        sh_lower[sh_free_idx] <= frm_lower;
        sh_ts[sh_free_idx] <= ts_cap;
        sh_dlc[sh_free_idx] <= rx_dlc;
        sh_data[sh_free_idx] <= rx_data;
        sh_target[sh_free_idx] <= rx_pick[3:0]; // R20
      end
    end
  end

  // ------------------------------------------------------------
  // Timer, lock and host reads
  // ------------------------------------------------------------
  wire rd_busy = xfer_busy && (xfer_slot == host_sel);
  wire rd_is_rx = !slot_code[host_sel][3];
  wire [15:0] rd_word = mem[host_sel][host_word];
  wire [15:0] rd_value = (host_word == W_RSV) ? 16'h0000 :
    (ctrl_rd && rd_busy) ? (rd_word | CODE_BUSY_MASK) : rd_word; // R15

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer <= TIMER_RESET;
      ts_cap <= TIMER_RESET;
      timer_rdata <= TIMER_RESET;
      host_rdata <= WORD_RESET;
      lock_valid <= 1'b0;
      lock_slot <= 4'h0;
      rx_dropped <= 1'b0;
      tx_pending <= 16'h0000;
    end
    else
    begin
      timer <= timer + 16'h0001;
      rx_dropped <= rx_match && !sh_free_ok;
      tx_pending <= tx_ready;
      if (rx_id_start)
        ts_cap <= timer; // R24
      if (timer_rd)
      begin
        timer_rdata <= timer;
        lock_valid <= 1'b0; // R17
      end
      if (host_rd)
        host_rdata <= rd_value;
      if (ctrl_rd && !rd_busy)
      begin
        lock_valid <= rd_is_rx; // R14 R16
        lock_slot <= host_sel; // R16
      end
    end
  end

  // ------------------------------------------------------------
  // Slot memory updates
  // ------------------------------------------------------------
  wire tx_rtr = slot_rtr[tx_slot];
  wire [3:0] tx_code = slot_code[tx_slot];
  wire [3:0] next_tx_code = (tx_code == TX_ONCE) ?
    (tx_rtr ? RX_EMPTY : TX_NOT_READY) : TX_REMOTE; // R23
  wire tx_upd = tx_done && (tx_code[3] == 1'b1) && (tx_code != TX_NOT_READY);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int s = 0; s < NUM_SLOTS; s++)
        for (int w = 0; w < SLOT_WORDS; w++)
          mem[s][w] <= WORD_RESET;
    end
    else
    begin
      // Deactivated during the transfer: frame is discarded
      if (xfer_done && dest_live)
      begin
        mem[xfer_slot][W_CTRL] <= {sh_ts[xfer_sh][15:8], next_rx_code,
          sh_dlc[xfer_sh]}; // R22 R24
        mem[xfer_slot][W_UPPER] <= sh_upper[xfer_sh]; // R2 R3
        mem[xfer_slot][W_LOWER] <= sh_lower[xfer_sh]; // R5 R7
        for (int d = 0; d < 4; d++)
          mem[xfer_slot][3'(d) + W_DATA0] <=
            sh_data[xfer_sh][63 - 16 * d -: 16];
      end
      if (remote_pick[4])
        mem[remote_pick[3:0]][W_CTRL][CODE_LSB+:4] <= TX_ONCE_REMOTE; // R1
      if (tx_upd)
      begin
        mem[tx_slot][W_CTRL][CODE_LSB+:4] <= next_tx_code; // R23
        mem[tx_slot][W_CTRL][TS_LSB+:8] <= ts_cap[15:8]; // R24
      end
      if (host_wr && host_word != W_RSV)
        mem[host_sel][host_word] <= host_wdata; // R12
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_busy_clears;
    @(posedge clk) disable iff (!rst_n)
    xfer_start |=> xfer_busy ##[1:20] !xfer_busy;
  endproperty
  a_busy_clears: assert property (p_busy_clears) // R22
    else $error("busy state held longer than twenty cycles");

  property p_locked_no_fill;
    @(posedge clk) disable iff (!rst_n)
    xfer_busy |-> !(lock_valid && lock_slot == xfer_slot);
  endproperty
  a_locked_no_fill: assert property (p_locked_no_fill) // R14
    else $error("slot locked while being filled");

  property p_busy_read;
    @(posedge clk) disable iff (!rst_n)
    ctrl_rd && rd_busy |=> host_rdata[CODE_LSB] &&
      !(lock_valid && lock_slot == $past(host_sel));
  endproperty
  a_busy_read: assert property (p_busy_read) // R15
    else $error("busy read did not show busy or set a lock");

  property p_read_locks;
    @(posedge clk) disable iff (!rst_n)
    ctrl_rd && !rd_busy && rd_is_rx |=>
      lock_valid && lock_slot == $past(host_sel);
  endproperty
  a_read_locks: assert property (p_read_locks) // R16
    else $error("receive control read did not move the lock");

  property p_timer_release;
    @(posedge clk) disable iff (!rst_n)
    timer_rd && !ctrl_rd |=> !lock_valid;
  endproperty
  a_timer_release: assert property (p_timer_release) // R17
    else $error("timer read did not release the lock");

  property p_remote_answer;
    @(posedge clk) disable iff (!rst_n)
    remote_pick[4] && !host_wr && !tx_done |=>
      slot_code[$past(remote_pick[3:0])] == TX_ONCE_REMOTE;
  endproperty
  a_remote_answer: assert property (p_remote_answer) // R1
    else $error("remote request did not arm the answer slot");

endmodule // can_message_buffer_filter

/* verif/can_frame_source.sv */
// Receive-side engine model that feeds frames into the slots
`timescale 1ns/10ps
module can_frame_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench request: go may pulse for one cycle, fields held until the frame is out
  input wire logic go,
  input wire logic [28:0] go_id,
  input wire logic go_ide,
  input wire logic go_rtr,
  input wire logic [67:0] go_pay,
  // Frame towards the block
  output logic rx_id_start,
  output logic rx_frame_valid,
  output logic [28:0] rx_id,
  output logic rx_ide,
  output logic rx_rtr,
  output logic rx_srr,
  output logic [67:0] rx_pay
);
  logic [2:0] step;
  // ------------------------------------------------------------
  // Frame sequencing
  // ------------------------------------------------------------
  // Between frames the lines toggle so stale values never pass
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step <= 3'h0;
      rx_id_start <= 1'h0;
      rx_frame_valid <= 1'h0;
      {rx_id, rx_ide, rx_rtr, rx_srr, rx_pay} <= '0;
    end
    else
    begin
      step <= (go || step != 3'h0) ? step + 3'h1 : 3'h0;
      rx_id_start <= go;
      rx_frame_valid <= (step == 3'h3);
      rx_id <= (step == 3'h3) ? (go_ide ? go_id : {go_id[28:18], 18'h0})
        : ~rx_id;
      rx_ide <= (step == 3'h3) ? go_ide : ~rx_ide;
      rx_rtr <= (step == 3'h3) ? go_rtr : ~rx_rtr;
      rx_srr <= (step == 3'h3) ? 1'h1 : ~rx_srr;
      rx_pay <= (step == 3'h3) ? go_pay : ~rx_pay;
    end
  end
endmodule // can_frame_source

/* verif/tb_can_message_buffer_filter.sv */
// Self-checking bench for the message slot block
`timescale 1ns/10ps
module tb_can_message_buffer_filter;
  import can_buf_pkg::*;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic clk = 1'h0, rst_n = 1'h0;
  slot_idx_t host_sel = 4'h0, tx_slot = 4'h0, lock_slot;
  logic [2:0] host_word = 3'h0;
  logic host_rd = 1'h0, host_wr = 1'h0, timer_rd = 1'h0, tx_done = 1'h0;
  logic bit_strobe = 1'h0, bit_sent = 1'h0, bit_seen = 1'h0, go = 1'h0;
  logic go_ide = 1'h0, go_rtr = 1'h0, cal = 1'h0;
  logic [15:0] host_wdata = 16'h0000, host_rdata, timer_rdata, tx_pending;
  logic [28:0] global_mask = '1, mask14 = '1, mask15 = '1, go_id = '0;
  logic [67:0] go_pay = '0, rx_pay;
  logic rx_id_start, rx_frame_valid, rx_ide, rx_rtr, rx_srr, rx_dropped;
  logic [28:0] rx_id, ida, idb, idc, idr;
  logic arb_lost, bit_error, bit_ok, lock_valid;
  logic [15:0] m [16][8];
  logic [15:0] rd_val, toff, fcap, tc = 16'h0000;
  int n_mismatch = 0, total_checks = 0, cyc = 0, pend = -1, lk = -1;

  always #50 clk = ~clk;
  always @(posedge clk) tc <= rst_n ? tc + 16'h0001 : 16'h0000;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  can_message_buffer_filter i_dut (.clk(clk), .rst_n(rst_n),
    .host_sel(host_sel), .host_word(host_word), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .timer_rd(timer_rd), .timer_rdata(timer_rdata),
    .global_mask(global_mask), .mask14(mask14), .mask15(mask15),
    .rx_id_start(rx_id_start), .rx_frame_valid(rx_frame_valid),
    .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_srr(rx_srr),
    .rx_dlc(rx_pay[67:64]), .rx_data(rx_pay[63:0]),
    .rx_dropped(rx_dropped), .tx_done(tx_done), .tx_slot(tx_slot),
    .tx_pending(tx_pending), .bit_strobe(bit_strobe),
    .bit_sent(bit_sent), .bit_seen(bit_seen), .arb_lost(arb_lost),
    .bit_error(bit_error), .bit_ok(bit_ok), .lock_valid(lock_valid),
    .lock_slot(lock_slot));

  can_frame_source i_src (.clk(clk), .rst_n(rst_n), .go(go),
    .go_id(go_id), .go_ide(go_ide), .go_rtr(go_rtr), .go_pay(go_pay),
    .rx_id_start(rx_id_start), .rx_frame_valid(rx_frame_valid),
    .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_srr(rx_srr),
    .rx_pay(rx_pay));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic lockchk();
    chk("lock", 16'({lk >= 0, 4'(lk)}),
      16'({lock_valid, lock_valid ? lock_slot : 4'hF}));
  endtask

  task automatic host(input logic rd, wr, input int s, w,
    input logic [15:0] d);
    @(posedge clk);
    host_sel <= 4'(s);
    host_word <= 3'(w);
    host_rd <= rd;
    host_wr <= wr;
    host_wdata <= d;
    @(posedge clk);
    host_rd <= 1'h0;
    host_wr <= 1'h0;
    #1 rd_val = host_rdata;
  endtask

  task automatic store(input int s);
    logic [3:0] c;
    c = (m[s][0][7:4] == RX_EMPTY) ? RX_FULL : RX_OVERRUN;
    m[s][0] = {fcap[15:8], c, go_pay[67:64]};
    m[s][1] = go_ide ? {go_id[28:18], 2'h3, go_id[17:15]}
      : {go_id[28:18], 5'h00};
    m[s][2] = go_ide ? {go_id[14:0], 1'h0} : fcap;
    for (int k = 0; k < 4; k++)
      m[s][3 + k] = go_pay[63 - 16 * k -: 16];
  endtask

  // A held frame lands once the lock leaves its slot
  task automatic relock(input int s);
    if (pend >= 0 && pend != s)
    begin
      repeat (10) @(posedge clk);
      store(pend);
      pend = -1;
    end
    lk = s;
  endtask

  task automatic trd();
    @(posedge clk);
    timer_rd <= 1'h1;
    @(posedge clk);
    timer_rd <= 1'h0;
    #1 rd_val = timer_rdata;
    if (!cal)
      toff = rd_val - tc;
    cal = 1'h1;
    chk("timer", tc + toff, rd_val);
    relock(-1);
    lockchk();
  endtask

  task automatic rdc(input int s);
    host(1'h1, 1'h0, s, 0, 16'h0000);
    chk("ctrl", m[s][0], rd_val);
    relock(m[s][0][7] ? -1 : s);
    lockchk();
  endtask

  task automatic checkall(input int s);
    for (int w = 1; w < 8; w++)
    begin
      host(1'h1, 1'h0, s, w, 16'h0000);
      chk("word", m[s][w], rd_val);
    end
    rdc(s);
  endtask

  task automatic wr(input int s, w, input logic [15:0] d);
    host(1'h0, 1'h1, s, w, d);
    m[s][w] = d;
  endtask

  task automatic setup(input int s, input logic [28:0] id,
    input logic ide, input logic [3:0] c);
    wr(s, 0, 16'h0000);
    wr(s, 1, ide ? {id[28:18], 2'h3, id[17:15]} : {id[28:18], 5'h00});
    wr(s, 2, ide ? {id[14:0], 1'h0} : 16'h0000);
    wr(s, 0, {8'h00, c, 4'h8});
  endtask

  function automatic bit hit(int s, logic [28:0] id, logic ide);
    logic [28:0] mk, sid;
    mk = s == 15 ? mask15 : s == 14 ? mask14 : global_mask;
    sid = {m[s][1][15:5], m[s][1][2:0], m[s][2][15:1]};
    if (!ide)
      mk[17:0] = 18'h0;
    return m[s][1][3] == ide && ((id ^ sid) & mk) == 0;
  endfunction

  task automatic pendchk();
    logic [15:0] e;
    for (int k = 0; k < 16; k++)
      e[k] = m[k][0][7:4] inside {TX_ONCE, TX_ONCE_REMOTE};
    chk("pending", e, tx_pending);
  endtask

  task automatic frame(input logic [28:0] id, input logic ide, rtr, peek);
    int s;
    @(posedge clk);
    go_id <= id;
    go_ide <= ide;
    go_rtr <= rtr;
    go_pay <= {4'($urandom_range(8)), 32'($urandom), 32'($urandom)};
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (4) @(posedge clk);
    #1 fcap = tc + toff - 16'h3;
    chk("drop", 0, 16'(rx_dropped));
    if (peek)
    begin
      repeat (1) @(posedge clk);
      host(1'h1, 1'h0, 5, 0, 16'h0000);
      chk("busy", CODE_BUSY_MASK, rd_val & CODE_BUSY_MASK);
      lockchk();
    end
    repeat (12) @(posedge clk);
    s = -1;
    for (int k = 15; k >= 0; k--)
      if (hit(k, id, ide) && (rtr ? m[k][0][7:4] == TX_REMOTE
          : m[k][0][7:4] inside {RX_EMPTY, RX_FULL, RX_OVERRUN}))
        s = k;
    if (s >= 0 && rtr)
      m[s][0][7:4] = TX_ONCE_REMOTE;
    else if (s >= 0 && s == lk)
      pend = s;
    else if (s >= 0)
      store(s);
  endtask

  task automatic txd(input int s);
    logic r;
    r = m[s][1][3] ? m[s][2][0] : m[s][1][4];
    @(posedge clk);
    tx_done <= 1'h1;
    tx_slot <= 4'(s);
    @(posedge clk);
    tx_done <= 1'h0;
    repeat (3) @(posedge clk);
    m[s][0][15:8] = fcap[15:8];
    m[s][0][7:4] = m[s][0][7:4] != TX_ONCE ? TX_REMOTE
      : r ? RX_EMPTY : TX_NOT_READY;
    rdc(s);
    pendchk();
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    for (int s = 0; s < 128; s++)
      m[s / 8][s % 8] = 16'h0000;
    rd_val = 16'($urandom(11029));
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    trd();
    checkall(0);
    ida = 29'($urandom);
    idb = {11'($urandom), 18'h0};
    idc = 29'($urandom);
    idr = 29'($urandom);
    setup(2, ida, 1'h1, RX_EMPTY);
    setup(5, idb, 1'h0, RX_EMPTY);
    setup(14, idc, 1'h1, RX_EMPTY);
    setup(7, idr, 1'h1, TX_REMOTE);
    setup(9, idc, 1'h0, TX_ONCE);
    mask14 <= 29'h1FFFFFF7;
    mask15 <= 29'($urandom);
    frame(ida, 1'h1, 1'h0, 1'h0);
    checkall(2);
    frame(idb, 1'h0, 1'h0, 1'h1);
    checkall(5);
    frame(idc ^ 29'h8, 1'h1, 1'h0, 1'h0);
    checkall(14);
    frame(idc ^ 29'h10, 1'h1, 1'h0, 1'h0);
    checkall(14);
    frame({ida[28:18], 18'h0}, 1'h0, 1'h0, 1'h0);
    checkall(2);
    frame(ida, 1'h1, 1'h0, 1'h0);
    checkall(2);
    rdc(5);
    checkall(2);
    trd();
    wr(5, 0, 16'h0000);
    frame(idb, 1'h0, 1'h0, 1'h0);
    checkall(5);
    frame(idr, 1'h1, 1'h1, 1'h0);
    pendchk();
    checkall(7);
    txd(7);
    txd(9);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      bit_strobe <= 1'h1;
      bit_sent <= k[1];
      bit_seen <= k[0];
      @(posedge clk);
      bit_strobe <= 1'h0;
      #1 chk("bits", {13'h0, k == 2, k == 1, k == 0 || k == 3},
        {13'h0, arb_lost, bit_error, bit_ok});
    end
    give_verdict();
  end
endmodule // tb_can_message_buffer_filter
